// >>> dv/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic start_cond();
		#50 sda_low_o = 1'b0;
		#50 scl_o = 1'b1;
		#100 sda_low_o = 1'b1;
		#100 scl_o = 1'b0;
	endtask

	task automatic stop_cond();
		#50 sda_low_o = 1'b1;
		#50 scl_o = 1'b1;
		#100 sda_low_o = 1'b0;
		#100;
	endtask

	// Data changes mid low phase, so it is settled over the high phase
	task automatic put_bit(input logic b, output logic seen);
		#50 sda_low_o = !b;
		#50 scl_o = 1'b1;
		#50 seen = sda_i;
		#50 scl_o = 1'b0;
	endtask

	// Ninth bit: 1 releases for the device, 0 is the master's own ack
	task automatic xfer(input logic [7:0] tx, input logic last,
		output logic [7:0] rx, output logic nine);
		for (int i = 7; i >= 0; i--)
			put_bit(tx[i], rx[i]);
		put_bit(last, nine);
	endtask
endmodule

// >>> dv/lcd_cmd_asserts.sv
`timescale 1ns/1ps
module lcd_cmd_asserts
	import lcd_cmd_pkg::*;
(
	input wire logic                  clock_i,
	input wire logic                  rst_i,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_o,
	input wire logic                  scl_i,
	input wire logic                  busy_o,
	input wire logic                  cmd_mode_o,
	input wire logic                  read_mode_o,
	input lcd_cmd_pkg::drive_cfg_type drive_cfg_o,
	input wire logic [5:0]            column_ptr_o,
	input wire logic                  rd_req_o,
	input wire logic                  data_valid_o,
	input lcd_cmd_pkg::data_word_type data_o,
	input wire logic                  data_ready_i
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence read_pulse_s;
		rd_req_o ##1 !rd_req_o;
	endsequence

	sequence cmd_taken_s;
		$past(cmd_mode_o) && !read_mode_o;
	endsequence

	idle_release_a: assert property (!busy_o |-> !sda_oe_o)
		else $error("data line driven while bus idle");
	pull_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("data line driven high");
	high_stable_a: assert property (
		scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("data drive changed while clock high");
	start_seen_a: assert property ($rose(busy_o) |-> !sda_i)
		else $error("busy rose without start");
	stop_seen_a: assert property ($fell(busy_o) |-> sda_i)
		else $error("busy fell without stop");
	read_pulse_a: assert property (
		rd_req_o |-> !cmd_mode_o ##0 read_pulse_s)
		else $error("read request outside a read pulse");
	mode_cmd_a: assert property (
		$changed(drive_cfg_o) |-> cmd_taken_s)
		else $error("drive mode changed without command");
	column_cmd_a: assert property (
		$changed(column_ptr_o) |-> cmd_taken_s)
		else $error("column changed without command");
	data_hold_a: assert property (
		data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_o))
		else $error("data word lost while stalled");
endmodule

// >>> dv/lcd_driver_command_decoder_bench.sv
`timescale 1ns/1ps
module lcd_driver_command_decoder_bench;
	import lcd_cmd_pkg::*;
	logic          clock_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          scl;
	logic          sda_low;
	logic          sda_oe;
	logic          sda_drv;
	logic          sa0;
	logic          busy;
	logic          cmd_mode;
	logic          read_mode;
	drive_cfg_type drive_cfg;
	logic [1:0]    top_bank;
	logic [3:0]    subaddr;
	ram_cfg_type   ram_cfg;
	logic [5:0]    column;
	logic [7:0]    rd_byte;
	logic          rd_req;
	logic          data_valid;
	data_word_type data_w;
	logic          data_ready;
	logic          hold_ready;
	wire           sda_wire = !(sda_oe | sda_low);
	int            seed = 92974;
	int            fails = 0;
	int            checked = 0;
	data_word_type exp_q[$];
	logic [7:0]    rd_q[$];

	always #12.5 clock_i = !clock_i;

	bus_master_model u_master (.scl_o(scl), .sda_low_o(sda_low),
		.sda_i(sda_wire));

	lcd_driver_command_decoder u_dut (.clock_i(clock_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_drv), .sda_oe_o(sda_oe),
		.sa0_i(sa0), .busy_o(busy), .cmd_mode_o(cmd_mode),
		.read_mode_o(read_mode), .drive_cfg_o(drive_cfg),
		.top_bank_o(top_bank), .subaddr_o(subaddr), .ram_cfg_o(ram_cfg),
		.column_ptr_o(column), .rd_byte_i(rd_byte), .rd_req_o(rd_req),
		.data_valid_o(data_valid), .data_o(data_w),
		.data_ready_i(data_ready));

	task automatic end_of_test();
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_val(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_word(input data_word_type exp,
		input data_word_type got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch data expected %h seen %h", exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] b, input logic exp_ack);
		logic [7:0] rx;
		logic       nine;
		u_master.xfer(b, 1'b1, rx, nine);
		chk_val("ack", {7'h00, exp_ack}, {7'h00, !nine});
	endtask

	// Consumer stalls at random unless the buffer is to be filled
	always @(posedge clock_i)
	begin
		#2 data_ready = hold_ready ? 1'b0 : 1'($random(seed));
	end

	always @(posedge clock_i)
		if (!rst_i && data_valid && data_ready)
			chk_word(exp_q.pop_front(), data_w);

	// The byte just taken is noted, then the next one is offered
	always @(posedge clock_i)
		if (rd_req)
		begin
			rd_q.push_back(rd_byte);
			#2 rd_byte = 8'($random(seed));
		end

	initial
	begin
		#1_000_000;
		fails++;
		end_of_test();
	end

	initial
	begin
		logic [7:0] v;
		logic [7:0] rx;
		logic       nine;
		sa0 = 1'($random(seed));
		rd_byte = 8'($random(seed));
		data_ready = 1'b1;
		hold_ready = 1'b0;
		repeat (3) @(posedge clock_i);
		#2 rst_i = 1'b0;
		repeat (4) @(posedge clock_i);
		// Bus pins move off the sampling edge from here on
		#2;
		chk_val("reset", {1'b0, drive_cfg, top_bank}, 8'h00);
		u_master.start_cond();
		wr({SLAVE_ADDR_BASE, sa0, 1'b0}, 1'b1);
		chk_val("busy", {7'h00, busy}, 8'h01);
		chk_val("cmd_mode", {7'h00, cmd_mode}, 8'h01);
		for (int i = 0; i < 32; i++)
		begin
			wr({3'h6, 5'(i)}, 1'b1);
			chk_val("mode", {3'h0, drive_cfg}, 8'(i));
		end
		for (int i = 0; i < 12; i++)
		begin
			wr({4'hF, 4'(i)}, 1'b1);
			chk_val("ram", {4'h0, ram_cfg}, 8'(i));
		end
		for (int i = 0; i < 4; i++)
		begin
			wr({6'h3F, 2'(i)}, 1'b1);
			chk_val("bank", {ram_cfg, 2'h0, top_bank},
				{4'hB, 2'h0, 2'(i)});
		end
		for (int i = 0; i < 16; i++)
		begin
			wr({4'hE, 4'(i)}, 1'b1);
			chk_val("subaddr", {4'h0, subaddr}, 8'(i));
		end
		v = 8'(($random(seed) & 32'hFF) % 40);
		wr({2'h2, v[5:0]}, 1'b1);
		chk_val("column", {2'h0, column}, v);
		wr(8'h27, 1'b1);
		chk_val("column", {2'h0, column}, 8'h27);
		chk_val("cmd_mode", {7'h00, cmd_mode}, 8'h00);
		hold_ready = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			v = 8'($random(seed));
			if (i != 2)
				exp_q.push_back({i == 0, v});
			wr(v, i != 2);
			if (i == 2)
				hold_ready = 1'b0;
		end
		chk_val("column", {2'h0, column}, 8'h27);
		u_master.stop_cond();
		chk_val("busy", {7'h00, busy}, 8'h00);
		u_master.start_cond();
		wr({SLAVE_ADDR_BASE, !sa0, 1'b0}, 1'b0);
		wr(8'h05, 1'b0);
		u_master.stop_cond();
		chk_val("column", {2'h0, column}, 8'h27);
		u_master.start_cond();
		wr({SLAVE_ADDR_BASE, sa0, 1'b1}, 1'b1);
		chk_val("read_mode", {7'h00, read_mode}, 8'h01);
		u_master.xfer(8'hFF, 1'b0, rx, nine);
		chk_val("read", rd_q.pop_front(), rx);
		u_master.xfer(8'hFF, 1'b1, rx, nine);
		chk_val("read", rd_q.pop_front(), rx);
		repeat (6) @(posedge clock_i);
		#2;
		chk_val("drive", {7'h00, sda_drv}, 8'h00);
		chk_val("release", {7'h00, sda_oe}, 8'h00);
		chk_val("column", {2'h0, column}, 8'h27);
		u_master.stop_cond();
		repeat (100) @(posedge clock_i);
		chk_val("drained", 8'(exp_q.size()), 8'h00);
		#2 rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#2 rst_i = 1'b0;
		repeat (2) @(posedge clock_i);
		chk_val("reset", {1'b0, drive_cfg, top_bank}, 8'h00);
		end_of_test();
	end
endmodule

bind lcd_driver_command_decoder lcd_cmd_asserts u_chk (
	.clock_i(clock_i), .rst_i(rst_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .scl_i(scl_i), .busy_o(busy_o),
	.cmd_mode_o(cmd_mode_o), .read_mode_o(read_mode_o),
	.drive_cfg_o(drive_cfg_o), .column_ptr_o(column_ptr_o),
	.rd_req_o(rd_req_o), .data_valid_o(data_valid_o), .data_o(data_o),
	.data_ready_i(data_ready_i));

// >>> pkg/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

	// Serial slave address: upper six bits fixed, low bit from the strap
	localparam logic [5:0] SLAVE_ADDR_BASE = 6'h1E;
	localparam logic [2:0] LAST_BIT        = 3'h7;
	localparam logic [2:0] BIT_CNT_RESET   = 3'h0;

	// Command byte fields
	localparam int CONT_BIT      = 7;
	localparam int OP_MSB_BIT    = 6;
	localparam int OP_MODE_BIT   = 5;
	localparam int OP_SUBADR_BIT = 4;
	localparam logic [1:0] BANK_OPCODE = 2'h3;

	// Reset values; a blank display after power-on
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MUX_RESET    = 2'h0;
	localparam logic [1:0] BANK_RESET   = 2'h0;
	localparam logic [3:0] SUBADR_RESET = 4'h0;
	localparam logic [5:0] COLUMN_RESET = 6'h00;
	localparam logic [7:0] BYTE_RESET   = 8'h00;

	typedef enum logic [2:0] {
		CMD_COLUMN = 3'b000,
		CMD_MODE   = 3'b001,
		CMD_SUBADR = 3'b010,
		CMD_BANK   = 3'b011,
		CMD_ACCESS = 3'b100
	} cmd_type;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_ADDR      = 3'b001,
		ST_ADDR_ACK  = 3'b010,
		ST_WRITE     = 3'b011,
		ST_WRITE_ACK = 3'b100,
		ST_READ      = 3'b101,
		ST_READ_ACK  = 3'b110,
		ST_IGNORE    = 3'b111
	} bus_state_type;

	typedef struct packed {
		logic       system_mixed;
		logic [1:0] display_status;
		logic [1:0] mux_rate;
	} drive_cfg_type;

	typedef struct packed {
		logic [1:0] access_pattern;
		logic [1:0] bank_sel;
	} ram_cfg_type;

	typedef struct packed {
		logic       first;
		logic [7:0] value;
	} data_word_type;

	localparam drive_cfg_type DRIVE_RESET = '{1'b0, STATUS_RESET, MUX_RESET};
	localparam ram_cfg_type   RAM_RESET   = '{2'h0, BANK_RESET};
	localparam data_word_type WORD_RESET  = '{1'b0, BYTE_RESET};

	// Start-bank pattern is tested ahead of RAM access
	function automatic cmd_type decode_cmd(input logic [7:0] b);
		cmd_type c;
		c = CMD_ACCESS;
		if (!b[OP_MSB_BIT])
			c = CMD_COLUMN;
		else if (!b[OP_MODE_BIT])
			c = CMD_MODE;
		else if (!b[OP_SUBADR_BIT])
			c = CMD_SUBADR;
		else if (b[3:2] == BANK_OPCODE)
			c = CMD_BANK;
		return c;
	endfunction

endpackage

// >>> verilog/lcd_driver_command_decoder.sv
`timescale 1ns/1ps
module lcd_driver_command_decoder
	import lcd_cmd_pkg::*;
(
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_o,
	input  wire logic                       sa0_i,
	output logic                            busy_o,
	output logic                            cmd_mode_o,
	output logic                            read_mode_o,
	output lcd_cmd_pkg::drive_cfg_type      drive_cfg_o,
	output logic [1:0]                      top_bank_o,
	output logic [3:0]                      subaddr_o,
	output lcd_cmd_pkg::ram_cfg_type        ram_cfg_o,
	output logic [5:0]                      column_ptr_o,
	input  wire logic [7:0]                 rd_byte_i,
	output logic                            rd_req_o,
	output logic                            data_valid_o,
	output lcd_cmd_pkg::data_word_type      data_o,
	input  wire logic                       data_ready_i
);
	logic [2:0]    pins_sync;
	logic          scl_s;
	logic          sda_s;
	logic          sa0_s;
	logic          scl_prev_reg;
	logic          sda_prev_reg;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_seen;
	logic          stop_seen;
	bus_state_type state_reg;
	logic [2:0]    bit_cnt_reg;
	logic [7:0]    shift_reg;
	logic [7:0]    rx_byte;
	logic [7:0]    tx_reg;
	logic          ack_phase_reg;
	logic          ack_en_reg;
	logic          first_data_reg;
	logic          push_valid_reg;
	data_word_type push_data_reg;
	logic          buf_ready;
	logic          last_bit;
	logic          addr_match;
	cmd_type       cmd;

	// Bus pins and the address strap are outside this clock
	sync_2ff #(
		.WIDTH     (3),
		.RESET_VAL (3'h7)
	) u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i ({scl_i, sda_i, sa0_i}),
		.sync_o  (pins_sync)
	);

	assign scl_s = pins_sync[2];
	assign sda_s = pins_sync[1];
	assign sa0_s = pins_sync[0];

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	assign scl_rise   = scl_s & !scl_prev_reg;
	assign scl_fall   = !scl_s & scl_prev_reg;
	assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & !sda_s;
	assign stop_seen  = scl_s & scl_prev_reg & !sda_prev_reg & sda_s;
	assign last_bit   = bit_cnt_reg == LAST_BIT;
	assign rx_byte    = {shift_reg[6:0], sda_s};
	assign addr_match = rx_byte[7:1] == {SLAVE_ADDR_BASE, sa0_s};
	assign cmd        = decode_cmd(rx_byte);

	// Bus protocol engine
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg     <= ST_IDLE;
			bit_cnt_reg   <= BIT_CNT_RESET;
			shift_reg     <= BYTE_RESET;
			tx_reg        <= BYTE_RESET;
			ack_phase_reg <= 1'b0;
			ack_en_reg    <= 1'b0;
			sda_oe_o      <= 1'b0;
			read_mode_o   <= 1'b0;
		end
		else if (stop_seen)
		begin
			state_reg     <= ST_IDLE;
			sda_oe_o      <= 1'b0;
			ack_phase_reg <= 1'b0;
		end
		else if (start_seen)
		begin
			state_reg     <= ST_ADDR;
			bit_cnt_reg   <= BIT_CNT_RESET;
			sda_oe_o      <= 1'b0;
			ack_phase_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE, ST_IGNORE:
				begin
					sda_oe_o <= 1'b0;
				end
				ST_ADDR, ST_WRITE:
				begin
					if (scl_rise)
					begin
						shift_reg   <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (last_bit)
						begin
							bit_cnt_reg <= BIT_CNT_RESET;
							if (state_reg == ST_ADDR)
							begin
								state_reg   <= addr_match ? ST_ADDR_ACK
									: ST_IGNORE;
								read_mode_o <= rx_byte[0];
								ack_en_reg  <= 1'b1;
								tx_reg      <= rd_byte_i;
							end
							else
							begin
								state_reg  <= ST_WRITE_ACK;
								ack_en_reg <= cmd_mode_o || buf_ready;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_WRITE_ACK:
				begin
					if (scl_fall && !ack_phase_reg)
					begin
						ack_phase_reg <= 1'b1;
						sda_oe_o      <= ack_en_reg;
					end
					else if (scl_fall)
					begin
						ack_phase_reg <= 1'b0;
						if (state_reg == ST_ADDR_ACK && read_mode_o)
						begin
							sda_oe_o  <= !tx_reg[7];
							tx_reg    <= {tx_reg[6:0], 1'b0};
							state_reg <= ST_READ;
						end
						else
						begin
							sda_oe_o  <= 1'b0;
							state_reg <= ST_WRITE;
						end
					end
				end
				ST_READ:
				begin
					if (scl_fall && bit_cnt_reg != BIT_CNT_RESET)
					begin
						sda_oe_o <= !tx_reg[7];
						tx_reg   <= {tx_reg[6:0], 1'b0};
					end
					else if (scl_fall)
					begin
						sda_oe_o <= !tx_reg[7];
						tx_reg   <= {tx_reg[6:0], 1'b0};
					end
					if (scl_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (last_bit)
						begin
							bit_cnt_reg <= BIT_CNT_RESET;
							state_reg   <= ST_READ_ACK;
						end
					end
				end
				ST_READ_ACK:
				begin
					if (scl_fall)
						sda_oe_o <= 1'b0;
					if (scl_rise && sda_s)
						state_reg <= ST_IGNORE;
					else if (scl_rise)
					begin
						state_reg <= ST_READ;
						tx_reg    <= rd_byte_i;
					end
				end
			endcase
		end
	end

	// Open-drain style: only ever drives low
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			busy_o <= 1'b0;
		else if (stop_seen)
			busy_o <= 1'b0;
		else if (start_seen)
			busy_o <= 1'b1;
	end

	// Next read byte is requested when a matched read address or a master ack takes one
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rd_req_o <= 1'b0;
		else
			rd_req_o <= (state_reg == ST_ADDR && scl_rise && last_bit
				&& addr_match && rx_byte[0])
				|| (state_reg == ST_READ_ACK && scl_rise && !sda_s);
	end

	// Command or data phase within a write transfer
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cmd_mode_o     <= 1'b0;
			first_data_reg <= 1'b0;
		end
		else if (state_reg == ST_ADDR && scl_rise && last_bit)
		begin
			cmd_mode_o     <= !rx_byte[0];
			first_data_reg <= 1'b1;
		end
		else if (state_reg == ST_WRITE && scl_rise && last_bit)
		begin
			if (cmd_mode_o)
				cmd_mode_o <= rx_byte[CONT_BIT];
			else if (buf_ready)
				first_data_reg <= 1'b0;
		end
	end

	// Command execution
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			drive_cfg_o  <= DRIVE_RESET;
			top_bank_o   <= BANK_RESET;
			subaddr_o    <= SUBADR_RESET;
			ram_cfg_o    <= RAM_RESET;
			column_ptr_o <= COLUMN_RESET;
		end
		else if (state_reg == ST_WRITE && scl_rise && last_bit
			&& cmd_mode_o)
		begin
			unique case (cmd)
				CMD_COLUMN:
					column_ptr_o <= rx_byte[5:0];
				CMD_MODE:
				begin
					drive_cfg_o.mux_rate       <= rx_byte[1:0];
					drive_cfg_o.display_status <= rx_byte[3:2];
					drive_cfg_o.system_mixed   <= rx_byte[4];
				end
				CMD_SUBADR:
					subaddr_o <= rx_byte[3:0];
				CMD_BANK:
					top_bank_o <= rx_byte[1:0];
				CMD_ACCESS:
				begin
					ram_cfg_o.access_pattern <= rx_byte[3:2];
					ram_cfg_o.bank_sel       <= rx_byte[1:0];
				end
			endcase
		end
	end

	// Display data goes to the buffer; a full buffer withholds the ack
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			push_valid_reg <= 1'b0;
			push_data_reg  <= WORD_RESET;
		end
		else
		begin
			push_valid_reg <= state_reg == ST_WRITE && scl_rise && last_bit
				&& !cmd_mode_o && buf_ready;
			push_data_reg  <= '{first_data_reg, rx_byte};
		end
	end

	skid_buffer u_buffer (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (push_valid_reg),
		.in_data_i   (push_data_reg),
		.in_ready_o  (buf_ready),
		.out_valid_o (data_valid_o),
		.out_data_o  (data_o),
		.out_ready_i (data_ready_i)
	);

endmodule

// >>> verilog/skid_buffer.sv
`timescale 1ns/1ps
module skid_buffer
	import lcd_cmd_pkg::*;
(
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	input  wire logic                       in_valid_i,
	input  lcd_cmd_pkg::data_word_type      in_data_i,
	output logic                            in_ready_o,
	output logic                            out_valid_o,
	output lcd_cmd_pkg::data_word_type      out_data_o,
	input  wire logic                       out_ready_i
);
	// Two entries: the output register and one spare
	logic          spare_valid_reg;
	data_word_type spare_data_reg;
	logic          take;
	logic          give;

	assign take = in_valid_i & in_ready_o;
	assign give = out_valid_o & out_ready_i;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_valid_o     <= 1'b0;
			out_data_o      <= WORD_RESET;
			spare_valid_reg <= 1'b0;
			spare_data_reg  <= WORD_RESET;
			in_ready_o      <= 1'b1;
		end
		else
		begin
			if (!out_valid_o || give)
			begin
				if (spare_valid_reg)
				begin
					out_data_o      <= spare_data_reg;
					out_valid_o     <= 1'b1;
					spare_valid_reg <= take;
					spare_data_reg  <= in_data_i;
				end
				else
				begin
					out_data_o  <= in_data_i;
					out_valid_o <= take;
				end
			end
			else if (take)
			begin
				spare_valid_reg <= 1'b1;
				spare_data_reg  <= in_data_i;
			end
			in_ready_o <= !((spare_valid_reg || take) && out_valid_o
				&& !give) || (!spare_valid_reg && !take);
		end
	end
endmodule

// >>> verilog/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
	parameter int         WIDTH     = 1,
	parameter logic [2:0] RESET_VAL = 3'h7
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_reg <= RESET_VAL[WIDTH-1:0];
			sync_o   <= RESET_VAL[WIDTH-1:0];
		end
		else
		begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule
